//--- rtl/abx_pkg.sv
package abx_pkg;
    localparam int ABX_XLEN = 32;
    localparam logic [31:0] ABX_RESET_PC = 32'h0000_0000;
    localparam logic [31:0] ABX_INSN_STEP = 32'h0000_0002;
    localparam logic [31:0] ABX_PC_BASE_OFS = 32'h0000_0004;
    // opcode match patterns (mask, value)
    localparam logic [15:0] ABX_ADD_OVERFLOW_CHECK_MASK = 16'hf00f;
    localparam logic [15:0] ABX_ADD_OVERFLOW_CHECK_VAL = 16'h300f;
    localparam logic [15:0] ABX_ANDR_MASK = 16'hf00f;
    localparam logic [15:0] ABX_ANDR_VAL = 16'h2009;
    localparam logic [15:0] ABX_HI8_MASK = 16'hff00;
    localparam logic [15:0] ABX_ANDI_VAL = 16'hc900;
    localparam logic [15:0] ABX_ANDM_VAL = 16'hcd00;
    localparam logic [15:0] ABX_BF_VAL = 16'h8b00;
    localparam logic [15:0] ABX_BFS_VAL = 16'h8f00;
    localparam logic [15:0] ABX_HI4_MASK = 16'hf000;
    localparam logic [15:0] ABX_BRA_VAL = 16'ha000;
    // cycle counts
    localparam logic [1:0] ABX_CYC_BF_TAKEN = 2'h3;
    localparam logic [1:0] ABX_CYC_DLY_TAKEN = 2'h2;
    localparam logic [1:0] ABX_CYC_ANDM = 2'h3;

    typedef enum logic [2:0] {
        ABX_ST_FETCH,
        ABX_ST_EXEC,
        ABX_ST_MEM_RD,
        ABX_ST_MEM_WR,
        ABX_ST_STALL
    } abx_state_e;

    // data memory request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [31:0] addr;
        logic [7:0] wdata;
    } abx_dmem_s;
endpackage : abx_pkg

//--- rtl/abx_core.sv
// How it works
// - overflow add sums src_reg into dest_reg in one cycle
// - test flag set when operand signs match and result sign differs, else cleared
// - register AND stores into dest_reg, one cycle, test flag untouched
// - immediate AND on reg_zero with zero-extended byte, upper 24 bits cleared
// - byte memory AND at global base plus reg_zero, read-modify-write, 3 cycles
// - branch_if_flag_clear jumps when flag is 0, target from pc plus 4
// - conditional displacement sign-extended from 8 bits and doubled
// - non-delayed conditional branch: 3 cycles taken, 1 cycle not taken
// - plain conditional or unconditional jump in a delay slot is an illegal slot
// - delayed conditional branch runs slot then jumps; 2 cycles taken, 1 not
// - taken delayed conditional branch blocks interrupts, flags branch in slot
// - untaken delayed conditional branch acts as nop, allows interrupts, no slot check
// - delayed target computed before slot executes; slot cannot alter it
// - unconditional delayed jump always branches after slot, 2 cycles
// - 12-bit displacement sign-extended, doubled, added to pc plus 4
// - unconditional delayed jump blocks interrupts, flags branch in its slot
// - branch or undefined code in a slot raises slot-invalid instead of running
module abx_core
    import abx_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic [15:0] insn_in,
    input wire logic insn_valid_in,
    input wire logic [7:0] dmem_rdata_in,
    input wire logic dmem_ack_in,
    input wire logic [31:0] global_base_register_in,
    output logic [31:0] fetch_addr_out,
    output logic fetch_req_out,
    output abx_dmem_s dmem_out,
    output logic test_flag_out,
    output logic [31:0] reg_zero_out,
    output logic int_allow_out,
    output logic slot_invalid_out,
    output logic undef_out
);
    logic [31:0] gpr_reg [16];
    logic [31:0] pc_reg;
    logic t_reg;
    abx_state_e state_reg;
    logic [1:0] cyc_reg;
    logic in_slot_reg;
    logic slot_mem_reg;
    logic [31:0] dly_target_reg;
    logic [7:0] imm_reg;
    logic [31:0] fetch_addr_reg;
    logic fetch_req_reg;
    abx_dmem_s dmem_reg;
    logic int_allow_reg;
    logic slot_invalid_reg;
    logic undef_reg;

    // decode
    logic [3:0] rn;
    logic [3:0] rm;
    logic is_add_overflow_check, is_andr, is_andi, is_andm, is_bf, is_bfs, is_bra, is_known, is_branch;
    logic [31:0] disp8, disp12, pc_base, sum;
    logic ovf;
    assign rn = insn_in[11:8];
    assign rm = insn_in[7:4];
    assign is_add_overflow_check = (insn_in & ABX_ADD_OVERFLOW_CHECK_MASK) == ABX_ADD_OVERFLOW_CHECK_VAL;
    assign is_andr = (insn_in & ABX_ANDR_MASK) == ABX_ANDR_VAL;
    assign is_andi = (insn_in & ABX_HI8_MASK) == ABX_ANDI_VAL;
    assign is_andm = (insn_in & ABX_HI8_MASK) == ABX_ANDM_VAL;
    assign is_bf = (insn_in & ABX_HI8_MASK) == ABX_BF_VAL;
    assign is_bfs = (insn_in & ABX_HI8_MASK) == ABX_BFS_VAL;
    assign is_bra = (insn_in & ABX_HI4_MASK) == ABX_BRA_VAL;
    assign is_branch = is_bf | is_bfs | is_bra;
    assign is_known = is_add_overflow_check | is_andr | is_andi | is_andm | is_branch;
    assign disp8 = {{23{insn_in[7]}}, insn_in[7:0], 1'b0};
    assign disp12 = {{19{insn_in[11]}}, insn_in[11:0], 1'b0};
    assign pc_base = pc_reg + ABX_PC_BASE_OFS;
    assign sum = gpr_reg[rn] + gpr_reg[rm];
    // overflow: equal operand signs, different result sign
    assign ovf = (gpr_reg[rn][31] == gpr_reg[rm][31]) && (sum[31] != gpr_reg[rn][31]);

    logic exec_go;
    assign exec_go = state_reg == ABX_ST_EXEC && insn_valid_in;
    // a slot holding a branch or undefined code is trapped instead of executed
    logic slot_bad;
    assign slot_bad = in_slot_reg && (is_branch || !is_known);

    // sequencer: fetch, execute, stalls for taken non-delayed branches, memory states for byte rmw
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state_reg <= ABX_ST_FETCH;
            pc_reg <= ABX_RESET_PC;
            cyc_reg <= 2'h0;
            in_slot_reg <= 1'b0;
            dly_target_reg <= 32'h0;
            slot_mem_reg <= 1'b0;
            imm_reg <= 8'h0;
        end
        else
        begin
            unique case (state_reg)
                ABX_ST_FETCH:
                    state_reg <= ABX_ST_EXEC;
                ABX_ST_EXEC:
                    if (insn_valid_in)
                    begin
                        in_slot_reg <= 1'b0;
                        state_reg <= ABX_ST_FETCH;
                        if (slot_bad)
                            pc_reg <= pc_reg; // exception handler takes over
                        else if (in_slot_reg)
                        begin
                            pc_reg <= dly_target_reg;
                            // a byte rmw in the slot still runs its memory cycles first,
                            // otherwise the read request would hang with no state to end it
                            if (is_andm)
                            begin
                                imm_reg <= insn_in[7:0];
                                slot_mem_reg <= 1'b1;
                                state_reg <= ABX_ST_MEM_RD;
                            end
                        end
                        else if (is_bf && !t_reg)
                        begin
                            pc_reg <= pc_base + disp8;
                            cyc_reg <= ABX_CYC_BF_TAKEN - 2'h1;
                            state_reg <= ABX_ST_STALL;
                        end
                        else if ((is_bfs && !t_reg) || is_bra)
                        begin
                            // target latched now, before the slot writes any register
                            dly_target_reg <= pc_base + (is_bra ? disp12 : disp8);
                            in_slot_reg <= 1'b1;
                            pc_reg <= pc_reg + ABX_INSN_STEP;
                        end
                        else if (is_andm)
                        begin
                            imm_reg <= insn_in[7:0];
                            state_reg <= ABX_ST_MEM_RD;
                        end
                        else
                            pc_reg <= pc_reg + ABX_INSN_STEP;
                    end
                ABX_ST_MEM_RD:
                    if (dmem_ack_in)
                        state_reg <= ABX_ST_MEM_WR;
                ABX_ST_MEM_WR:
                    if (dmem_ack_in)
                    begin
                        // after a slot access pc already holds the branch target
                        if (!slot_mem_reg)
                            pc_reg <= pc_reg + ABX_INSN_STEP;
                        slot_mem_reg <= 1'b0;
                        state_reg <= ABX_ST_FETCH;
                    end
                ABX_ST_STALL:
                begin
                    cyc_reg <= cyc_reg - 2'h1;
                    if (cyc_reg == 2'h1)
                        state_reg <= ABX_ST_FETCH;
                end
                default:
                    state_reg <= ABX_ST_FETCH;
            endcase
        end
    end

    // register file and test flag
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            for (int i = 0; i < 16; i++)
                gpr_reg[i] <= 32'h0;
            t_reg <= 1'b0;
        end
        else if (exec_go && !slot_bad)
        begin
            if (is_add_overflow_check)
            begin
                gpr_reg[rn] <= sum;
                t_reg <= ovf;
            end
            else if (is_andr)
                gpr_reg[rn] <= gpr_reg[rn] & gpr_reg[rm];
            else if (is_andi)
                gpr_reg[0] <= {24'h0, gpr_reg[0][7:0] & insn_in[7:0]};
        end
    end

    // byte read-modify-write at global base plus reg_zero
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            dmem_reg <= '0;
        else if (exec_go && !slot_bad && is_andm)
        begin
            dmem_reg.rd <= 1'b1;
            dmem_reg.addr <= global_base_register_in + gpr_reg[0];
        end
        else if (state_reg == ABX_ST_MEM_RD && dmem_ack_in)
        begin
            dmem_reg.rd <= 1'b0;
            dmem_reg.wr <= 1'b1;
            dmem_reg.wdata <= dmem_rdata_in & imm_reg;
        end
        else if (state_reg == ABX_ST_MEM_WR && dmem_ack_in)
            dmem_reg.wr <= 1'b0;
    end

    // fetch port and event outputs
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            fetch_addr_reg <= ABX_RESET_PC;
            fetch_req_reg <= 1'b0;
            int_allow_reg <= 1'b0;
            slot_invalid_reg <= 1'b0;
            undef_reg <= 1'b0;
        end
        else
        begin
            fetch_req_reg <= state_reg == ABX_ST_FETCH;
            fetch_addr_reg <= pc_reg;
            slot_invalid_reg <= exec_go && slot_bad;
            undef_reg <= exec_go && !in_slot_reg && !is_known;
            // interrupts held off between a taken delayed branch and its slot
            if (exec_go)
                int_allow_reg <= !(!in_slot_reg && ((is_bfs && !t_reg) || is_bra));
        end
    end

    assign fetch_addr_out = fetch_addr_reg;
    assign fetch_req_out = fetch_req_reg;
    assign dmem_out = dmem_reg;
    assign test_flag_out = t_reg;
    assign reg_zero_out = gpr_reg[0];
    assign int_allow_out = int_allow_reg;
    assign slot_invalid_out = slot_invalid_reg;
    assign undef_out = undef_reg;

    property p_add_overflow_check_flag;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (exec_go && !slot_bad && is_add_overflow_check) |=> (t_reg == (($past(gpr_reg[rn][31]) ==
            $past(gpr_reg[rm][31])) && (gpr_reg[$past(rn)][31] != $past(gpr_reg[rn][31]))));
    endproperty
    a_add_overflow_check_flag: assert property (p_add_overflow_check_flag) else $error("overflow flag wrong");

    property p_add_overflow_check_sum;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (exec_go && !slot_bad && is_add_overflow_check) |=>
            (gpr_reg[$past(rn)] == $past(gpr_reg[rn]) + $past(gpr_reg[rm]));
    endproperty
    a_add_overflow_check_sum: assert property (p_add_overflow_check_sum) else $error("overflow add sum wrong");

    property p_andr_keeps_t;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (exec_go && is_andr) |=> $stable(t_reg);
    endproperty
    a_andr_keeps_t: assert property (p_andr_keeps_t) else $error("and changed flag");

    property p_andi_upper;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (exec_go && !slot_bad && is_andi) |=> (gpr_reg[0][31:8] == 24'h0);
    endproperty
    a_andi_upper: assert property (p_andi_upper) else $error("upper bits kept");

    property p_bf_taken;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (exec_go && !in_slot_reg && is_bf && !t_reg) |=> (state_reg == ABX_ST_STALL)[*2]
            ##1 (state_reg == ABX_ST_FETCH);
    endproperty
    a_bf_taken: assert property (p_bf_taken) else $error("taken branch cycles");

    property p_slot_trap;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (exec_go && in_slot_reg && is_branch) |=> slot_invalid_reg;
    endproperty
    a_slot_trap: assert property (p_slot_trap) else $error("slot branch not trapped");

    property p_bra_target;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (exec_go && !in_slot_reg && is_bra) |=> (dly_target_reg == $past(pc_base + disp12));
    endproperty
    a_bra_target: assert property (p_bra_target) else $error("jump target wrong");

    property p_no_int;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (exec_go && !in_slot_reg && is_bra) |=> !int_allow_reg;
    endproperty
    a_no_int: assert property (p_no_int) else $error("interrupt allowed in slot");

    property p_bfs_nt;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (exec_go && !in_slot_reg && is_bfs && t_reg) |=> (int_allow_reg && !in_slot_reg);
    endproperty
    a_bfs_nt: assert property (p_bfs_nt) else $error("untaken branch not nop");

    property p_slot_redirect;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (exec_go && in_slot_reg && !slot_bad) |=> (pc_reg == $past(dly_target_reg));
    endproperty
    a_slot_redirect: assert property (p_slot_redirect) else $error("no redirect");

    property p_andm_addr;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (exec_go && !slot_bad && is_andm) |=> (dmem_reg.rd
            && dmem_reg.addr == $past(global_base_register_in) + $past(gpr_reg[0]));
    endproperty
    a_andm_addr: assert property (p_andm_addr) else $error("byte access address wrong");

    property p_bfs_target;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        (exec_go && !in_slot_reg && is_bfs && !t_reg) |=> (in_slot_reg
            && dly_target_reg == $past(pc_reg) + ABX_PC_BASE_OFS
            + {{23{$past(insn_in[7])}}, $past(insn_in[7:0]), 1'b0});
    endproperty
    a_bfs_target: assert property (p_bfs_target) else $error("delayed target wrong");

    c_bf: cover property (@(posedge ref_clk_in) exec_go && is_bf && !t_reg);
    c_bra: cover property (@(posedge ref_clk_in) exec_go && is_bra);
    c_andm: cover property (@(posedge ref_clk_in) state_reg == ABX_ST_MEM_WR && dmem_ack_in);
    c_trap: cover property (@(posedge ref_clk_in) slot_invalid_reg);
endmodule : abx_core

//--- verif/abx_mem_model.sv
module abx_mem_model
    import abx_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [31:0] fetch_addr_in,
    input wire abx_dmem_s dmem_in,
    input wire logic [1:0] lat_in,
    output logic [15:0] insn_out,
    output logic insn_valid_out,
    output logic [7:0] rdata_out,
    output logic ack_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] prog [0:2047];
    logic [7:0] mem [0:255];
    logic [1:0] wait_cnt;
    // program store aliases every 4 kbyte, so far jumps land on low words
    assign insn_out = prog[fetch_addr_in[11:1]];
    assign insn_valid_out = nrst_in;
    // data port answers after a variable wait; read data toggles while idle
    // so a core that samples it outside the answer sees garbage
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            ack_out <= 1'b0;
            wait_cnt <= 2'h0;
            rdata_out <= 8'h00;
        end
        else if (!ack_out && (dmem_in.rd || dmem_in.wr) && wait_cnt >= lat_in)
        begin
            ack_out <= 1'b1;
            wait_cnt <= 2'h0;
            rdata_out <= mem[dmem_in.addr[7:0]];
            if (dmem_in.wr)
                mem[dmem_in.addr[7:0]] <= dmem_in.wdata;
        end
        else
        begin
            ack_out <= 1'b0;
            rdata_out <= ~rdata_out;
            if (!ack_out && (dmem_in.rd || dmem_in.wr))
                wait_cnt <= wait_cnt + 2'h1;
        end
    end
endmodule : abx_mem_model

//--- verif/add_overflow_check_and_branch_exec_tb.sv
module add_overflow_check_and_branch_exec_tb
    import abx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [15:0] insn;
    logic insn_valid;
    logic [7:0] rdata;
    logic ack;
    logic [31:0] global_base_register = 32'h0000_0000;
    logic [1:0] lat = 2'h0;
    logic [31:0] fetch_addr;
    logic fetch_req;
    abx_dmem_s dmem;
    logic flag;
    logic [31:0] r0;
    logic int_allow;
    logic slot_inv;
    logic undef;
    logic [31:0] exp_fetch[$];
    logic [40:0] exp_mem[$];
    logic [31:0] seed = 32'h75598a74;
    logic [31:0] lat_rng = 32'h75598a74;
    logic [7:0] imm1;
    logic [7:0] imm2;
    logic [7:0] mbyte;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;
    int n_undef = 0;
    int n_slot = 0;
    int n_block = 0;

    initial forever #20 ref_clk_in = ~ref_clk_in;

    abx_core i_abx_core (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .insn_in(insn),
        .insn_valid_in(insn_valid), .dmem_rdata_in(rdata), .dmem_ack_in(ack),
        .global_base_register_in(global_base_register), .fetch_addr_out(fetch_addr),
        .fetch_req_out(fetch_req), .dmem_out(dmem), .test_flag_out(flag),
        .reg_zero_out(r0), .int_allow_out(int_allow), .slot_invalid_out(slot_inv),
        .undef_out(undef));
    abx_mem_model i_abx_mem_model (.clk_in(ref_clk_in), .nrst_in(nrst_in),
        .fetch_addr_in(fetch_addr), .dmem_in(dmem), .lat_in(lat), .insn_out(insn),
        .insn_valid_out(insn_valid), .rdata_out(rdata), .ack_out(ack));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xs

    // branch target: sign-extended displacement doubled, based four bytes on
    function automatic logic [31:0] br(input logic [31:0] pc, input logic [11:0] d, input bit wide);
        logic [31:0] sd;
        sd = wide ? {{20{d[11]}}, d} : {{24{d[7]}}, d[7:0]};
        return pc + 32'h0000_0004 + (sd << 1);
    endfunction : br

    task automatic check(input string what, input logic [40:0] seen, input logic [40:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run

    // wait latency changes every cycle so the core meets fast and slow answers
    always @(posedge ref_clk_in)
    begin
        cycles++;
        lat_rng <= xs(lat_rng);
        lat <= lat_rng[1:0];
        if (cycles == 3000)
        begin
            miscompares++;
            complete_run();
        end
    end

    // monitor: every result takes the oldest note off its queue
    always @(posedge ref_clk_in)
    begin
        if (nrst_in)
        begin
            if (fetch_req === 1'b1 && exp_fetch.size() > 0)
                check("fetch address", fetch_addr, exp_fetch.pop_front());
            if (ack === 1'b1 && (dmem.rd || dmem.wr) && exp_mem.size() > 0)
                check("data access", {dmem.wr, dmem.addr, dmem.wr ? dmem.wdata : 8'h00}, exp_mem.pop_front());
            if (undef === 1'b1)
                n_undef++;
            if (slot_inv === 1'b1)
                n_slot++;
            if (int_allow === 1'b0 && n_slot == 0 && cycles > 8)
                n_block++;
        end
    end

    initial
    begin
        seed = xs(seed);
        imm1 = seed[7:0];
        imm2 = seed[15:8];
        mbyte = seed[23:16];
        for (int i = 0; i < 2048; i++)
            i_abx_mem_model.prog[i] = 16'h2009;
        // filler is a register AND of reg_zero with itself
        i_abx_mem_model.prog[0] = 16'hc900 | imm1;
        i_abx_mem_model.prog[1] = 16'h300f;
        i_abx_mem_model.prog[2] = 16'hcd00 | imm2;
        i_abx_mem_model.prog[3] = 16'h8b10;
        i_abx_mem_model.prog[21] = 16'h8ff0;
        i_abx_mem_model.prog[22] = 16'hcd00 | imm1; // byte and inside the delay slot
        i_abx_mem_model.prog[7] = 16'ha7ff;
        i_abx_mem_model.prog[9] = 16'hffff;
        i_abx_mem_model.prog[10] = 16'ha000;
        i_abx_mem_model.prog[11] = 16'h8b00;
        exp_fetch = '{32'h0, 32'h2, 32'h4, 32'h6, br(32'h6, 12'h010, 0), 32'h2c,
            br(32'h2a, 12'h0f0, 0), 32'h10, br(32'he, 12'h7ff, 1), 32'h1012, 32'h1014, 32'h1016};
        @(posedge ref_clk_in);
        seed = xs(seed);
        global_base_register <= seed;
        @(negedge ref_clk_in);
        i_abx_mem_model.mem[global_base_register[7:0]] = mbyte;
        exp_mem.push_back({1'b0, global_base_register, 8'h00});
        exp_mem.push_back({1'b1, global_base_register, mbyte & imm2});
        exp_mem.push_back({1'b0, global_base_register, 8'h00});
        exp_mem.push_back({1'b1, global_base_register, mbyte & imm2 & imm1});
        repeat (4) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        @(negedge ref_clk_in);
        check("reset pc", fetch_addr, 32'h0);
        check("reset flag", flag, 1'b0);
        $display("test reset done");
        for (int i = 0; i < 600 && !(exp_fetch.size() == 0 && n_slot > 0); i++)
            @(posedge ref_clk_in);
        repeat (4) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        check("fetch notes left", exp_fetch.size(), 0);
        check("data notes left", exp_mem.size(), 0);
        check("reg_zero", r0, 32'h0);
        check("test flag", flag, 1'b0);
        $display("test program done");
        check("slot invalid pulses", n_slot, 1);
        check("undefined pulses", n_undef, 1);
        check("interrupt block seen", n_block > 0, 1'b1);
        $display("test events done");
        complete_run();
    end
endmodule : add_overflow_check_and_branch_exec_tb
